// ==== pkg/task_file_map.svh ====
// Task-file offsets, field positions, codes and reset values.
// Assumes inclusion by bare name from the task-file design.
`ifndef TASK_FILE_MAP_SVH
`define TASK_FILE_MAP_SVH
`define TF_DATA_OFS 3'h0
`define TF_FAULT_OFS 3'h1
`define TF_COUNT_OFS 3'h2
`define TF_SECT_OFS 3'h3
`define TF_CYLLO_OFS 3'h4
`define TF_CYLHI_OFS 3'h5
`define FLT_CRC_BIT 7
`define FLT_UNC_BIT 6
`define FLT_SECTOR_MISSING_BIT 4
`define FLT_COMMAND_ABORTED_BIT 2
`define FLT_TK0_BIT 1
`define FLT_ADDRESS_MARK_MISSING_BIT 0
`define DIAG_OK 7'h01
`define DIAG_SLAVE_BIT 7
`define FEAT_XFER_MODE 8'h03
`define SMART_KEY_LO 8'h4f
`define SMART_KEY_HI 8'hc2
`define RST_COUNT 8'h01
`define RST_SECT 8'h01
`define RST_CYL 8'h00
`define FIRST_SECT 8'h01
`endif

// ==== pkg/task_file_pkg.sv ====
// Types shared by the task-file design.
// Assumes nothing beyond a SystemVerilog compiler.
package task_file_pkg;
   typedef struct packed {
      logic link_checksum_fault;
      logic uncorrectable_read_fault;
      logic sector_missing;
      logic command_aborted;
      logic home_track_missing;
      logic address_mark_missing;
   } fault_evt_t;
   typedef struct packed {
      logic [7:0] cyl_hi;
      logic [7:0] cyl_lo;
      logic [7:0] sect;
   } position_t;
   typedef enum logic [1:0] {
      MODE_DIAG = 2'b01,
      MODE_OPER = 2'b10
   } fault_mode_t;
endpackage

// ==== rtl/disk_task_file_registers.sv ====
// Command-block task file of a fixed disk: data port, fault/feature,
// count, sector and cylinder registers behind the host strobes.
// Assumes host pins are asynchronous; the engine shares clk_in.
// Function
// - Sixteen-bit data port at address zero
// - Long-command ECC bytes move byte-wide
// - Port also carries table, identify, passwords
// - Bit 7 on Ultra DMA CRC error
// - Bits 6,4,1,0 on read/seek faults
// - Bit 2 on aborted command
// - Removable-media bits 5,3 stay zero
// - Diagnostic code after reset or diagnostics
// - Diagnostic codes 01 to 05
// - Master ORs 80h for failed slave
// - Features give set-features sub-function
// - SMART subcommand from features value
// - Count zero means 256; ends zero
// - Count down, sector up per sector
// - Init parameters take count as geometry
// - Power command returns mode in count
// - Features 03h: count sets transfer mode
// - Sector register tracks last or failed sector
// - LBA bits 0-23 across three registers
// - Cylinder low/high hold current cylinder
// - Undefined bits read zero, writes ignored
`timescale 1ns/1ps
`include "task_file_map.svh"
module disk_task_file_registers (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic low_register_select_n_in,
   input wire logic [2:0] host_addr_in,
   input wire logic host_read_n_in,
   input wire logic host_write_n_in,
   input wire logic [15:0] host_data_in,
   output logic [15:0] host_data_out,
   output logic host_data_oe_out,
   output logic wide_select_n_out,
   input wire logic [15:0] buf_rd_data_in,
   output logic buf_rd_pop_out,
   output logic [15:0] buf_wr_data_out,
   output logic buf_wr_push_out,
   input wire logic byte_mode_in,
   input wire logic busy_in,
   input wire logic cmd_start_in,
   input wire task_file_pkg::fault_evt_t fault_in,
   input wire logic diag_done_in,
   input wire logic [6:0] diag_code_in,
   input wire logic slave_fail_in,
   input wire logic sector_done_in,
   input wire logic lba_mode_in,
   input wire logic spt_load_in,
   input wire logic feature_apply_in,
   input wire logic power_report_in,
   input wire logic [7:0] power_code_in,
   input wire logic pos_load_in,
   input wire task_file_pkg::position_t pos_in,
   output logic [7:0] feature_out,
   output logic [8:0] count_total_out,
   output logic [7:0] sectors_per_track_out,
   output logic [7:0] transfer_mode_out,
   output logic diag_mode_out,
   output logic error_flag_out,
   output task_file_pkg::position_t position_out,
   output logic smart_key_ok_out
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int PW = 22;
   logic [PW-1:0] pin_s1_reg;
   logic [PW-1:0] pin_s2_reg;
   logic [PW-1:0] pin_s3_reg;
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pin_s1_reg <= {6'h3f, 16'h0000};
         pin_s2_reg <= {6'h3f, 16'h0000};
         pin_s3_reg <= {6'h3f, 16'h0000};
      end
      else
      begin
         pin_s1_reg <= {low_register_select_n_in, host_addr_in, host_read_n_in,
                        host_write_n_in, host_data_in};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   // ----------------------------------------
   // Strobe decode
   // ----------------------------------------
   wire cs_n = pin_s2_reg[21];
   wire [2:0] addr = pin_s2_reg[20:18];
   wire rd_n = pin_s2_reg[17];
   wire rd_n_old = pin_s3_reg[17];
   wire wr_n = pin_s2_reg[16];
   wire wr_n_old = pin_s3_reg[16];
   wire [15:0] wr_word = pin_s3_reg[15:0];
   wire rd_start = rd_n_old && !rd_n && !cs_n;
   wire wr_end = !wr_n_old && wr_n && !cs_n;
   wire host_wr = wr_end && !busy_in;

   function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
      hit = (a == ofs);
   endfunction

   wire data_sel = hit(addr, `TF_DATA_OFS);
   wire wr_feat = host_wr && hit(addr, `TF_FAULT_OFS);
   wire wr_count = host_wr && hit(addr, `TF_COUNT_OFS);
   wire wr_sect = host_wr && hit(addr, `TF_SECT_OFS);
   wire wr_cyllo = host_wr && hit(addr, `TF_CYLLO_OFS);
   wire wr_cylhi = host_wr && hit(addr, `TF_CYLHI_OFS);

   // ----------------------------------------
   // Data port into the sector buffer
   // ----------------------------------------
   logic [15:0] rd_word_reg;
   logic [15:0] buf_wr_reg;
   logic push_reg;
   wire [15:0] buf_word = byte_mode_in ? {8'h00, buf_rd_data_in[7:0]} : buf_rd_data_in;
   wire [15:0] host_word = byte_mode_in ? {8'h00, wr_word[7:0]} : wr_word;
   assign buf_rd_pop_out = rd_start && data_sel;
   assign wide_select_n_out = !(!cs_n && data_sel && !byte_mode_in);
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         buf_wr_reg <= 16'h0000;
         push_reg <= 1'b0;
      end
      else
      begin
         push_reg <= wr_end && data_sel;
         if (wr_end && data_sel)
            buf_wr_reg <= host_word;
      end
   end
   assign buf_wr_data_out = buf_wr_reg;
   assign buf_wr_push_out = push_reg;

   // ----------------------------------------
   // Fault register and its two modes
   // ----------------------------------------
   task_file_pkg::fault_mode_t mode_reg;
   task_file_pkg::fault_mode_t mode_next;
   logic [7:0] fault_reg;
   logic [7:0] fault_next;
   logic [7:0] evt_bits;
   wire any_evt = |fault_in;
   always_comb
   begin
      evt_bits = 8'h00;
      evt_bits[`FLT_CRC_BIT] = fault_in.link_checksum_fault;
      evt_bits[`FLT_UNC_BIT] = fault_in.uncorrectable_read_fault;
      evt_bits[`FLT_SECTOR_MISSING_BIT] = fault_in.sector_missing;
      evt_bits[`FLT_COMMAND_ABORTED_BIT] = fault_in.command_aborted;
      evt_bits[`FLT_TK0_BIT] = fault_in.home_track_missing;
      evt_bits[`FLT_ADDRESS_MARK_MISSING_BIT] = fault_in.address_mark_missing;
   end
   always_comb
   begin
      mode_next = mode_reg;
      fault_next = fault_reg;
      if (diag_done_in)
      begin
         mode_next = task_file_pkg::MODE_DIAG;
         fault_next = {slave_fail_in, diag_code_in};
      end
      else
      begin
         unique case (mode_reg)
            task_file_pkg::MODE_DIAG:
            begin
               if (cmd_start_in || any_evt)
               begin
                  mode_next = task_file_pkg::MODE_OPER;
                  fault_next = evt_bits;
               end
            end
            task_file_pkg::MODE_OPER:
            begin
               // Set wins over the clear at command start
               fault_next = (cmd_start_in ? 8'h00 : fault_reg) | evt_bits;
            end
            default:
            begin
               mode_next = task_file_pkg::MODE_OPER;
               fault_next = evt_bits;
            end
         endcase
      end
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         mode_reg <= task_file_pkg::MODE_DIAG;
         fault_reg <= {1'b0, `DIAG_OK};
      end
      else
      begin
         mode_reg <= mode_next;
         fault_reg <= fault_next;
      end
   end
   assign diag_mode_out = (mode_reg == task_file_pkg::MODE_DIAG);
   assign error_flag_out = !diag_mode_out && (|fault_reg);

   // ----------------------------------------
   // Features, count, sector and cylinder
   // ----------------------------------------
   logic [7:0] feat_reg;
   logic [7:0] count_reg;
   logic [7:0] spt_reg;
   logic [7:0] xmode_reg;
   task_file_pkg::position_t pos_reg;
   task_file_pkg::position_t pos_next;
   wire [23:0] lba_step = pos_reg + 24'h000001;
   wire sect_wrap = (pos_reg.sect == spt_reg) && (spt_reg != 8'h00);
   always_comb
   begin
      pos_next = pos_reg;
      if (pos_load_in)
         pos_next = pos_in;
      else if (sector_done_in && lba_mode_in)
         pos_next = lba_step;
      else if (sector_done_in)
         pos_next.sect = sect_wrap ? `FIRST_SECT : pos_reg.sect + 8'h01;
      if (wr_sect)
         pos_next.sect = wr_word[7:0];
      if (wr_cyllo)
         pos_next.cyl_lo = wr_word[7:0];
      if (wr_cylhi)
         pos_next.cyl_hi = wr_word[7:0];
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         pos_reg <= {`RST_CYL, `RST_CYL, `RST_SECT};
      else
         pos_reg <= pos_next;
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         count_reg <= `RST_COUNT;
      else if (wr_count)
         count_reg <= wr_word[7:0];
      else if (power_report_in)
         count_reg <= power_code_in;
      else if (sector_done_in)
         count_reg <= count_reg - 8'h01;
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         feat_reg <= 8'h00;
         spt_reg <= 8'h00;
         xmode_reg <= 8'h00;
      end
      else
      begin
         if (wr_feat)
            feat_reg <= wr_word[7:0];
         if (spt_load_in)
            spt_reg <= count_reg;
         if (feature_apply_in && feat_reg == `FEAT_XFER_MODE)
            xmode_reg <= count_reg;
      end
   end
   assign feature_out = feat_reg;
   assign count_total_out = (count_reg == 8'h00) ? 9'h100 : {1'b0, count_reg};
   assign sectors_per_track_out = spt_reg;
   assign transfer_mode_out = xmode_reg;
   assign position_out = pos_reg;
   assign smart_key_ok_out = (pos_reg.cyl_lo == `SMART_KEY_LO) && (pos_reg.cyl_hi == `SMART_KEY_HI);

   // ----------------------------------------
   // Host read path
   // ----------------------------------------
   logic [15:0] rd_sel;
   always_comb
   begin
      unique case (addr)
         `TF_DATA_OFS: rd_sel = buf_word;
         `TF_FAULT_OFS: rd_sel = {8'h00, fault_reg};
         `TF_COUNT_OFS: rd_sel = {8'h00, count_reg};
         `TF_SECT_OFS: rd_sel = {8'h00, pos_reg.sect};
         `TF_CYLLO_OFS: rd_sel = {8'h00, pos_reg.cyl_lo};
         `TF_CYLHI_OFS: rd_sel = {8'h00, pos_reg.cyl_hi};
         default: rd_sel = 16'h0000;
      endcase
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         rd_word_reg <= 16'h0000;
      else if (rd_start)
         rd_word_reg <= rd_sel;
   end
   assign host_data_out = rd_word_reg;
   assign host_data_oe_out = !cs_n && !rd_n && (addr <= `TF_CYLHI_OFS);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_data_read;
      rd_start && data_sel;
   endsequence
   sequence s_sector_step;
      sector_done_in && !wr_count && !power_report_in;
   endsequence
   property p_pop;
      s_data_read |-> buf_rd_pop_out ##1 (rd_word_reg == $past(buf_word));
   endproperty
   a_pop: assert property (p_pop) else $error("data read did not pop buffer");
   property p_wide;
      byte_mode_in |-> wide_select_n_out && (buf_word[15:8] == 8'h00);
   endproperty
   a_wide: assert property (p_wide) else $error("byte mode drove wide path");
   property p_crc;
      fault_in.link_checksum_fault && !diag_done_in |=> fault_reg[7] && !diag_mode_out;
   endproperty
   a_crc: assert property (p_crc) else $error("crc fault not recorded");
   property p_read_faults;
      fault_in.uncorrectable_read_fault && !diag_done_in |=> fault_reg[6] && error_flag_out;
   endproperty
   a_read_faults: assert property (p_read_faults) else $error("read fault not recorded");
   property p_abort;
      fault_in.command_aborted && cmd_start_in && !diag_done_in |=> fault_reg[2];
   endproperty
   a_abort: assert property (p_abort) else $error("abort lost at command start");
   property p_removable;
      !diag_mode_out |-> (fault_reg[5] == 1'b0) && (fault_reg[3] == 1'b0);
   endproperty
   a_removable: assert property (p_removable) else $error("removable bit set");
   property p_slave;
      diag_done_in && slave_fail_in |=> diag_mode_out && !error_flag_out && fault_reg[7];
   endproperty
   a_slave: assert property (p_slave) else $error("slave failure not reported");
   property p_count;
      s_sector_step |=> count_reg == $past(count_reg) - 8'h01;
   endproperty
   a_count: assert property (p_count) else $error("count not decremented");
   property p_lba;
      sector_done_in && lba_mode_in && !pos_load_in && !host_wr |=> pos_reg == $past(lba_step);
   endproperty
   a_lba: assert property (p_lba) else $error("lba not advanced");
   property p_xmode;
      feature_apply_in && feat_reg == `FEAT_XFER_MODE |=> xmode_reg == $past(count_reg);
   endproperty
   a_xmode: assert property (p_xmode) else $error("transfer mode not taken");
   property p_total;
      count_reg == 8'h00 |-> count_total_out == 9'h100;
   endproperty
   a_total: assert property (p_total) else $error("zero count not 256");
endmodule

// ==== tb/host_bus_model.sv ====
// Host controller model for the task-file register bus.
// Assumes the bench calls write_reg/read_reg; strobes held 4+ clocks.
`timescale 1ns/1ps
module host_bus_model (
   input wire logic clk_in,
   output logic cs_n_out,
   output logic [2:0] addr_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic [15:0] data_out,
   input wire logic [15:0] dev_data_in,
   input wire logic dev_oe_in,
   input wire logic wide_n_in,
   output logic rd_valid_out,
   output logic [16:0] rd_word_out
);
   // Undriven bus shows inverse of last host value
   wire [15:0] bus_level = dev_oe_in ? dev_data_in : ~data_out;
   initial
   begin
      cs_n_out = 1'b1;
      addr_out = 3'h7;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      data_out = 16'h0000;
      rd_valid_out = 1'b0;
      rd_word_out = 17'h00000;
   end
   task automatic write_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_in);
      #1;
      cs_n_out = 1'b0;
      addr_out = a;
      data_out = d;
      wr_n_out = 1'b0;
      repeat (4) @(posedge clk_in);
      #1 wr_n_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 cs_n_out = 1'b1;
      data_out = ~d;
   endtask
   task automatic read_reg(input logic [2:0] a);
      @(posedge clk_in);
      #1;
      cs_n_out = 1'b0;
      addr_out = a;
      rd_n_out = 1'b0;
      repeat (6) @(posedge clk_in);
      #1 rd_word_out = {wide_n_in, bus_level};
      rd_valid_out = 1'b1;
      @(posedge clk_in);
      #1 rd_valid_out = 1'b0;
      rd_n_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 cs_n_out = 1'b1;
   endtask
endmodule

// ==== tb/tb_disk_task_file_registers.sv ====
// Self-checking bench for the task-file register block.
// Assumes host_bus_model on the host pins; engine side driven here.
`timescale 1ns/1ps
module tb_disk_task_file_registers;
   logic clk_in, rst_in, byte_mode_in, busy_in, slave_fail_in, lba_mode_in;
   logic [15:0] buf_rd_data_in, host_data_out, buf_wr_data_out;
   logic [6:0] diag_code_in;
   logic [7:0] power_code_in, evt, feature_out, sectors_per_track_out, transfer_mode_out;
   logic [5:0] fault_v;
   logic [8:0] count_total_out;
   logic [16:0] rd_word;
   logic [2:0] h_addr;
   logic h_cs_n, h_rd_n, h_wr_n, rd_valid, oe, wide_n, pop, push, diag_mode_out, error_flag_out, smart_ok;
   logic [15:0] h_data;
   task_file_pkg::position_t pos_in, position_out;
   logic [16:0] rd_q[$];
   logic [15:0] wr_q[$];
   logic [31:0] seed, v;
   int n_errors = 0, checks_done = 0, cycles = 0, n_pops = 0;
   logic [7:0] fmask[6] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h02, 8'h01};

   host_bus_model host_u (.clk_in(clk_in), .cs_n_out(h_cs_n), .addr_out(h_addr), .rd_n_out(h_rd_n),
      .wr_n_out(h_wr_n), .data_out(h_data), .dev_data_in(host_data_out), .dev_oe_in(oe),
      .wide_n_in(wide_n), .rd_valid_out(rd_valid), .rd_word_out(rd_word));

   disk_task_file_registers dut_u (.clk_in(clk_in), .rst_in(rst_in), .low_register_select_n_in(h_cs_n),
      .host_addr_in(h_addr), .host_read_n_in(h_rd_n), .host_write_n_in(h_wr_n), .host_data_in(h_data),
      .host_data_out(host_data_out), .host_data_oe_out(oe), .wide_select_n_out(wide_n),
      .buf_rd_data_in(buf_rd_data_in), .buf_rd_pop_out(pop), .buf_wr_data_out(buf_wr_data_out),
      .buf_wr_push_out(push), .byte_mode_in(byte_mode_in), .busy_in(busy_in), .cmd_start_in(evt[5]),
      .fault_in(fault_v), .diag_done_in(evt[6]), .diag_code_in(diag_code_in), .slave_fail_in(slave_fail_in),
      .sector_done_in(evt[0]), .lba_mode_in(lba_mode_in), .spt_load_in(evt[1]), .feature_apply_in(evt[2]),
      .power_report_in(evt[3]), .power_code_in(power_code_in), .pos_load_in(evt[4]), .pos_in(pos_in),
      .feature_out(feature_out), .count_total_out(count_total_out),
      .sectors_per_track_out(sectors_per_track_out), .transfer_mode_out(transfer_mode_out),
      .diag_mode_out(diag_mode_out), .error_flag_out(error_flag_out), .position_out(position_out),
      .smart_key_ok_out(smart_ok));

   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   //----------------------------------------
   // Checking helpers
   //----------------------------------------
   task automatic check_val(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] d, input logic w);
      rd_q.push_back({w, d});
      host_u.read_reg(a);
   endtask
   task automatic pulse(input int b, input logic [5:0] f);
      @(posedge clk_in);
      #1 evt[b] = 1'b1;
      fault_v = f;
      @(posedge clk_in);
      #1 evt = 8'h00;
      fault_v = 6'h00;
   endtask
   always @(posedge clk_in)
   begin
      cycles++;
      if (pop === 1'b1)
         n_pops++;
      if (rd_valid === 1'b1)
      begin
         check_val("host read", {7'h00, rd_word}, {7'h00, rd_q.pop_front()});
         check_val("bus drive", oe, 24'h1);
      end
      if (push === 1'b1)
         check_val("buffer word", {8'h00, buf_wr_data_out}, {8'h00, wr_q.pop_front()});
      if (cycles == 5000)
      begin
         n_errors++;
         $display("Error timeout after %0d cycles", cycles);
         complete_run;
      end
   end
   //----------------------------------------
   // Main sequence
   //----------------------------------------
   initial
   begin
      seed = 32'ha067efa5;
      rst_in = 1'b1;
      {byte_mode_in, busy_in, slave_fail_in, lba_mode_in} = 4'h0;
      evt = 8'h00;
      fault_v = 6'h00;
      diag_code_in = 7'h00;
      power_code_in = 8'h00;
      pos_in = 24'h000000;
      buf_rd_data_in = $random(seed);
      repeat (5) @(posedge clk_in);
      #1 rst_in = 1'b0;
      repeat (3) @(posedge clk_in);
      rd(3'h1, 16'h0001, 1'b1);
      rd(3'h2, 16'h0001, 1'b1);
      check_val("diag mode", diag_mode_out, 24'h1);
      check_val("error flag", error_flag_out, 24'h0);
      host_u.write_reg(3'h2, 16'h0010);
      pulse(1, 6'h00);
      check_val("per track", sectors_per_track_out, 24'h10);
      host_u.write_reg(3'h1, 16'h0003);
      host_u.write_reg(3'h2, 16'h0005);
      pulse(2, 6'h00);
      check_val("xfer mode", transfer_mode_out, 24'h05);
      check_val("features", feature_out, 24'h03);
      for (int i = 3; i < 6; i++)
      begin
         v = $random(seed);
         host_u.write_reg(i[2:0], v[15:0]);
         rd(i[2:0], {8'h00, v[7:0]}, 1'b1);
      end
      busy_in = 1'b1;
      host_u.write_reg(3'h5, ~v[15:0]);
      busy_in = 1'b0;
      rd(3'h5, {8'h00, v[7:0]}, 1'b1);
      host_u.write_reg(3'h4, 16'h004f);
      host_u.write_reg(3'h5, 16'h00c2);
      check_val("smart key", smart_ok, 24'h1);
      host_u.write_reg(3'h2, 16'h0000);
      check_val("count 256", count_total_out, 24'h100);
      host_u.write_reg(3'h2, 16'h0003);
      host_u.write_reg(3'h3, 16'h0005);
      repeat (3) pulse(0, 6'h00);
      check_val("count end", count_total_out, 24'h100);
      rd(3'h2, 16'h0000, 1'b1);
      rd(3'h3, 16'h0008, 1'b1);
      rd(3'h4, 16'h004f, 1'b1);
      host_u.write_reg(3'h3, 16'h0010);
      pulse(0, 6'h00);
      rd(3'h3, 16'h0001, 1'b1);
      lba_mode_in = 1'b1;
      host_u.write_reg(3'h3, 16'h00ff);
      host_u.write_reg(3'h4, 16'h00ff);
      host_u.write_reg(3'h5, 16'h0000);
      host_u.write_reg(3'h2, 16'h0002);
      pulse(0, 6'h00);
      check_val("lba carry", position_out, 24'h010000);
      rd(3'h2, 16'h0001, 1'b1);
      v = $random(seed);
      pos_in = v[23:0];
      pulse(4, 6'h00);
      rd(3'h5, {8'h00, v[23:16]}, 1'b1);
      power_code_in = v[31:24];
      pulse(3, 6'h00);
      rd(3'h2, {8'h00, v[31:24]}, 1'b1);
      for (int k = 0; k < 6; k++)
      begin
         pulse(5, 6'h00);
         check_val("fault clear", {diag_mode_out, error_flag_out}, 24'h0);
         pulse(7, 6'h20 >> k);
         check_val("error flag", error_flag_out, 24'h1);
         rd(3'h1, {8'h00, fmask[k]}, 1'b1);
      end
      diag_code_in = 7'h05;
      slave_fail_in = 1'b1;
      pulse(6, 6'h00);
      rd(3'h1, 16'h0085, 1'b1);
      check_val("diag flags", {diag_mode_out, error_flag_out}, 24'h2);
      rd(3'h0, buf_rd_data_in, 1'b0);
      v = $random(seed);
      wr_q.push_back(v[15:0]);
      host_u.write_reg(3'h0, v[15:0]);
      byte_mode_in = 1'b1;
      wr_q.push_back({8'h00, v[23:16]});
      host_u.write_reg(3'h0, v[31:16]);
      rd(3'h0, {8'h00, buf_rd_data_in[7:0]}, 1'b1);
      byte_mode_in = 1'b0;
      repeat (4) @(posedge clk_in);
      check_val("pops", n_pops, 24'h2);
      check_val("left", rd_q.size() + wr_q.size(), 24'h0);
      complete_run;
   end
endmodule
